// ### design/video_consts.svh
// constants for the video path: field positions, code values, reset values
// assumes nothing; included by every design file that needs a number
`ifndef VIDEO_CONSTS_SVH
`define VIDEO_CONSTS_SVH

// frame field positions
`define SPACE_LSB 5
`define COLORIM_LSB 6
`define REPEAT_LSB 0

// colorimetry codes
`define COLORIM_HD 2'h2
`define COLORIM_EXT 2'h3

// value ranges
`define LUMA_OFS 8'h10
`define CHROMA_MID 8'h80
`define LIM_MIN 8'h10
`define LIM_MAX 8'heb
`define EMB_MIN 8'h01
`define EMB_MAX 8'hfe
`define FULL_MAX 8'hff

// embedded sync code bytes
`define CODE_FF 8'hff
`define CODE_00 8'h00

// reset values and measurement
`define RESET_REPEAT 4'h0
`define HD_LINES 12'h2d0

`endif

// ### design/video_pkg.sv
// types shared by the video path modules
// assumes 8-bit components on three channels
package video_pkg;

	// decoded color space field, in code order
	typedef enum logic [1:0] {space_rgb444, space_ycc422, space_ycc444, space_reserved} space_type;

	// output bus formats
	typedef enum logic [2:0] {fmt_rgb444_sep, fmt_ycc444_sep, fmt_ycc422_sep, fmt_ycc422_mux_sep,
		fmt_ycc422_mux_emb} format_type;

	// matrix operation
	typedef enum logic [1:0] {conv_pass, conv_rgb_to_ycc, conv_ycc_to_rgb} conv_type;

	// output formatter states
	typedef enum logic [1:0] {st_data, st_luma, st_code} fmt_state_type;

	// one pixel with its sync flags; a/b/c are R/G/B or Y/Cb/Cr
	typedef struct packed {
		logic sof;
		logic hsync;
		logic vsync;
		logic de;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] c;
	} pix_type;

	// fields taken from the video information frame
	typedef struct packed {
		logic [1:0] space;
		logic [1:0] colorim;
		logic [3:0] repeat_n;
	} info_type;

	// active video path configuration; all zero is the reset state
	typedef struct packed {
		logic powered;
		logic decrypt_on;
		logic conv_on;
		logic hd;
		logic ext;
		logic hs_inv;
		logic vs_inv;
		space_type space;
		logic [3:0] repeat_n;
		format_type fmt;
	} cfg_type;

endpackage

// ### design/async_fifo.sv
// dual-clock fifo with gray-coded pointers
// assumes DEPTH is a power of two, at least 4; resets assert asynchronously
`timescale 1ns/1ps
`default_nettype none

module async_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 8,
	parameter int AW = $clog2(DEPTH)
) (
	// write side
	input wire logic wr_clock,
	input wire logic wr_rst,
	input wire logic wr_valid,
	input wire logic [WIDTH-1:0] wr_data,
	output logic wr_ready,
	// read side
	input wire logic rd_clock,
	input wire logic rd_rst,
	output logic rd_valid,
	output logic [WIDTH-1:0] rd_data,
	input wire logic rd_ready
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wbin, wgray, rbin, rgray;
	logic [AW:0] rg_sync0, rg_sync1, wg_sync0, wg_sync1;

	// pointer arithmetic
	wire wr_fire = wr_valid & wr_ready;
	wire rd_fire = rd_valid & rd_ready;
	wire [AW:0] next_wbin = wbin + (AW+1)'(wr_fire);
	wire [AW:0] next_rbin = rbin + (AW+1)'(rd_fire);
	assign wr_ready = (wgray != {~rg_sync1[AW:AW-1], rg_sync1[AW-2:0]});
	assign rd_valid = (rgray != wg_sync1);
	assign rd_data = mem[rbin[AW-1:0]];

	// write domain: storage, pointer and the read pointer synchroniser
	always_ff @(posedge wr_clock) begin
		if (wr_fire) begin
			mem[wbin[AW-1:0]] <= wr_data;
		end
	end
	always_ff @(posedge wr_clock or posedge wr_rst) begin
		if (wr_rst) begin
			wbin <= '0;
			wgray <= '0;
			rg_sync0 <= '0;
			rg_sync1 <= '0;
		end else begin
			wbin <= next_wbin;
			wgray <= next_wbin ^ (next_wbin >> 1);
			rg_sync0 <= rgray;
			rg_sync1 <= rg_sync0;
		end
	end

	// read domain: pointer and the write pointer synchroniser
	always_ff @(posedge rd_clock or posedge rd_rst) begin
		if (rd_rst) begin
			rbin <= '0;
			rgray <= '0;
			wg_sync0 <= '0;
			wg_sync1 <= '0;
		end else begin
			rbin <= next_rbin;
			rgray <= next_rbin ^ (next_rbin >> 1);
			wg_sync0 <= wgray;
			wg_sync1 <= wg_sync0;
		end
	end
endmodule

`default_nettype wire

// ### design/color_matrix_converter.sv
// 3x3 color matrix with offsets and output clamp, one register stage
// assumes load is a single-cycle strobe from the owning pipeline
`timescale 1ns/1ps
`default_nettype none
`include "video_consts.svh"

module color_matrix_converter (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control
	input wire logic load,
	input wire video_pkg::conv_type mode,
	input wire logic hd,
	input wire logic ext,
	// pixels
	input wire video_pkg::pix_type pix_in,
	output video_pkg::pix_type pix_out
);
	// coefficients scaled by 256: rows sd/hd forward, sd/hd inverse
	localparam logic signed [10:0] coef [4][9] = '{
		'{11'sh042, 11'sh081, 11'sh019, -11'sh026, -11'sh04a, 11'sh070, 11'sh070, -11'sh05e, -11'sh012},
		'{11'sh02f, 11'sh09d, 11'sh010, -11'sh01a, -11'sh057, 11'sh070, 11'sh070, -11'sh066, -11'sh00a},
		'{11'sh12a, 11'sh000, 11'sh199, 11'sh12a, -11'sh064, -11'sh0d0, 11'sh12a, 11'sh204, 11'sh000},
		'{11'sh12a, 11'sh000, 11'sh1cb, 11'sh12a, -11'sh037, -11'sh088, 11'sh12a, 11'sh21d, 11'sh000}};

	// input offsets come off first when the source is YCbCr
	wire to_rgb = (mode == video_pkg::conv_ycc_to_rgb);
	wire [1:0] sel = {to_rgb, hd};
	wire signed [9:0] x0 = $signed({2'h0, pix_in.a}) - (to_rgb ? $signed({2'h0, `LUMA_OFS}) : 10'sh000);
	wire signed [9:0] x1 = $signed({2'h0, pix_in.b}) - (to_rgb ? $signed({2'h0, `CHROMA_MID}) : 10'sh000);
	wire signed [9:0] x2 = $signed({2'h0, pix_in.c}) - (to_rgb ? $signed({2'h0, `CHROMA_MID}) : 10'sh000);
	wire [23:0] res_bus;

	// extended gamut keeps 1..254 instead of the narrow span
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_ch
			wire signed [22:0] sum = coef[sel][3*i] * x0 + coef[sel][3*i+1] * x1 + coef[sel][3*i+2] * x2
				+ 23'sh000080;
			wire signed [14:0] scaled = sum[22:8];
			wire [7:0] ofs = to_rgb ? 8'h00 : ((i == 0) ? `LUMA_OFS : `CHROMA_MID);
			wire signed [14:0] val = scaled + $signed({7'h00, ofs});
			wire [7:0] lo = to_rgb ? 8'h00 : (ext ? `EMB_MIN : `LIM_MIN);
			wire [7:0] hi = to_rgb ? `FULL_MAX : (ext ? `EMB_MAX : `LIM_MAX);
			assign res_bus[23-8*i -: 8] = (val < $signed({7'h00, lo})) ? lo :
				((val > $signed({7'h00, hi})) ? hi : val[7:0]);
		end
	endgenerate

	// pass mode leaves the pixel untouched
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pix_out <= '0;
		end else if (load) begin
			pix_out <= pix_in;
			if (mode != video_pkg::conv_pass) begin
				{pix_out.a, pix_out.b, pix_out.c} <= res_bus;
			end
		end
	end
endmodule

`default_nettype wire

// ### design/video_path_color_autoconfig.sv
// video path: link capture, color conversion, auto configuration, output format
// assumes link pixels arrive one per link clock; settings are on the core clock
`timescale 1ns/1ps
`default_nettype none
`include "video_consts.svh"

module video_path_color_autoconfig #(
	parameter int FIFO_DEPTH = 8
) (
	// core clock and reset
	input wire logic clock,
	input wire logic rst,
	// link side, on the recovered pixel clock
	input wire logic link_clock,
	input wire logic link_hsync,
	input wire logic link_vsync,
	input wire logic link_de,
	input wire logic [7:0] link_ch0,
	input wire logic [7:0] link_ch1,
	input wire logic [7:0] link_ch2,
	output logic link_ready,
	// video information frame, link side
	input wire logic info_valid,
	input wire logic [7:0] info_byte1,
	input wire logic [7:0] info_byte2,
	input wire logic [7:0] info_byte5,
	// configuration, core clock
	input wire logic power_on,
	input wire logic auto_enable,
	input wire logic [1:0] manual_space,
	input wire logic [1:0] manual_colorim,
	input wire logic [3:0] manual_repeat,
	input wire logic conv_bypass,
	input wire logic repl_bypass,
	input wire logic decrypt_enable,
	input wire logic hsync_invert,
	input wire logic vsync_invert,
	input wire video_pkg::format_type out_format,
	// video output
	output video_pkg::pix_type out_pix,
	output logic out_valid,
	input wire logic out_ready,
	// status
	output video_pkg::cfg_type active_cfg,
	output logic info_seen,
	output logic measured_hd
);

	// ---------------- link domain ----------------

	// link reset: asserts with rst, releases on the link clock
	logic [1:0] link_rst_sync;
	wire link_rst = link_rst_sync[1];
	always_ff @(posedge link_clock or posedge rst) begin
		if (rst) begin
			link_rst_sync <= 2'h3;
		end else begin
			link_rst_sync <= {link_rst_sync[0], 1'b0};
		end
	end

	// frame start is the rising edge of vsync
	logic link_prev_vsync;
	video_pkg::pix_type link_word;
	assign link_word = {link_vsync & ~link_prev_vsync, link_hsync, link_vsync, link_de,
		link_ch0, link_ch1, link_ch2};
	always_ff @(posedge link_clock or posedge link_rst) begin
		if (link_rst) begin
			link_prev_vsync <= 1'b0;
		end else begin
			link_prev_vsync <= link_vsync;
		end
	end

	// frame fields are held stable until the core acknowledges them;
	// a frame that arrives while one is in flight is dropped, frames repeat anyway
	video_pkg::info_type info_hold;
	logic info_req;
	logic info_ack;
	logic [1:0] ack_sync;
	wire info_free = (info_req == ack_sync[1]);
	always_ff @(posedge link_clock or posedge link_rst) begin
		if (link_rst) begin
			info_hold <= '0;
			info_req <= 1'b0;
			ack_sync <= 2'h0;
		end else begin
			ack_sync <= {ack_sync[0], info_ack};
			if (info_valid && info_free) begin
				info_hold.space <= info_byte1[`SPACE_LSB +: 2];
				info_hold.colorim <= info_byte2[`COLORIM_LSB +: 2];
				info_hold.repeat_n <= info_byte5[`REPEAT_LSB +: 4];
				info_req <= ~info_req;
			end
		end
	end

	// ---------------- crossing ----------------

	// pixels cross in the fifo; the link sees back-pressure on link_ready
	video_pkg::pix_type rd_pix;
	logic rd_valid;
	logic rd_ready;
	async_fifo #(
		.WIDTH($bits(video_pkg::pix_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.wr_clock(link_clock),
		.wr_rst(link_rst),
		.wr_valid(~link_rst),
		.wr_data(link_word),
		.wr_ready(link_ready),
		.rd_clock(clock),
		.rd_rst(rst),
		.rd_valid(rd_valid),
		.rd_data(rd_pix),
		.rd_ready(rd_ready)
	);

	// frame fields cross by a toggle handshake
	logic [1:0] req_sync;
	video_pkg::info_type info_core;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			req_sync <= 2'h0;
			info_ack <= 1'b0;
			info_core <= '0;
			info_seen <= 1'b0;
		end else begin
			req_sync <= {req_sync[0], info_req};
			if (req_sync[1] != info_ack) begin
				info_ack <= req_sync[1];
				info_core <= info_hold;
				info_seen <= 1'b1;
			end
		end
	end

	// ---------------- core domain ----------------

	// resolution measurement: active lines counted per frame
	wire rd_fire = rd_valid & rd_ready;
	logic prev_de_in;
	logic [11:0] line_cnt;
	wire line_start = rd_pix.de & ~prev_de_in;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prev_de_in <= 1'b0;
			line_cnt <= 12'h000;
			measured_hd <= 1'b0;
		end else if (rd_fire) begin
			prev_de_in <= rd_pix.de;
			if (rd_pix.sof) begin
				measured_hd <= (line_cnt >= `HD_LINES);
				line_cnt <= 12'h000;
			end else if (line_start) begin
				line_cnt <= line_cnt + 12'h001;
			end
		end
	end

	// pending configuration; no frame seen means DVI-style RGB and measured definition
	wire [1:0] auto_space = info_seen ? info_core.space : 2'h0;
	wire [1:0] pend_space = auto_enable ? auto_space : manual_space;
	wire [1:0] auto_colorim = info_seen ? info_core.colorim : 2'h0;
	wire [1:0] colorim = auto_enable ? auto_colorim : manual_colorim;
	wire [3:0] auto_repeat = info_seen ? info_core.repeat_n : `RESET_REPEAT;
	wire [3:0] pend_repeat = repl_bypass ? `RESET_REPEAT : (auto_enable ? auto_repeat : manual_repeat);
	wire pend_hd = (colorim == `COLORIM_HD) | ((colorim[1] == colorim[0]) & measured_hd);
	wire pend_ext = (colorim == `COLORIM_EXT);
	video_pkg::cfg_type next_cfg;
	assign next_cfg = '{
		powered: power_on,
		decrypt_on: decrypt_enable,
		conv_on: ~conv_bypass,
		hd: pend_hd,
		ext: pend_ext,
		hs_inv: hsync_invert,
		vs_inv: vsync_invert,
		space: video_pkg::space_type'(pend_space),
		repeat_n: pend_repeat,
		fmt: out_format
	};

	// active configuration: the all-zero reset value is the default path,
	// loaded on a frame start so a frame is never half reconfigured, except powered, which follows power_on every clock
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_cfg <= '0;
		end else begin
			if (rd_fire && rd_pix.sof) begin
				active_cfg <= next_cfg;
			end
			active_cfg.powered <= power_on;
		end
	end

	// pixel repetition: keep the first copy of each group, realigned at line start
	logic [3:0] rep_cnt;
	wire [3:0] rep_phase = line_start ? 4'h0 : rep_cnt;
	wire keep = (rep_phase == 4'h0);
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rep_cnt <= 4'h0;
		end else if (rd_fire) begin
			rep_cnt <= (rep_phase == active_cfg.repeat_n) ? 4'h0 : rep_phase + 4'h1;
		end
	end

	// conversion direction follows input space versus output format
	wire out_rgb = (active_cfg.fmt == video_pkg::fmt_rgb444_sep);
	wire in_rgb = (active_cfg.space == video_pkg::space_rgb444);
	video_pkg::conv_type conv_mode;
	assign conv_mode = ~active_cfg.conv_on ? video_pkg::conv_pass :
		(out_rgb & ~in_rgb) ? video_pkg::conv_ycc_to_rgb :
		(~out_rgb & in_rgb) ? video_pkg::conv_rgb_to_ycc : video_pkg::conv_pass;

	// matrix stage; powered down the stream is drained and dropped
	logic s1_valid;
	logic fmt_take;
	video_pkg::pix_type s1_pix;
	wire mat_load = rd_fire & keep & active_cfg.powered;
	assign rd_ready = ~active_cfg.powered | ~s1_valid | fmt_take;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_valid <= 1'b0;
		end else if (mat_load) begin
			s1_valid <= 1'b1;
		end else if (fmt_take) begin
			s1_valid <= 1'b0;
		end
	end

	color_matrix_converter u_matrix (
		.clock(clock),
		.rst(rst),
		.load(mat_load),
		.mode(conv_mode),
		.hd(active_cfg.hd),
		.ext(active_cfg.ext),
		.pix_in(rd_pix),
		.pix_out(s1_pix)
	);

	// ---------------- output formatter ----------------

	// clamp used on data beats whenever sync codes are embedded
	function automatic logic [7:0] clamp_emb(input logic [7:0] v, input logic on);
		if (on && v < `EMB_MIN) begin
			return `EMB_MIN;
		end
		if (on && v > `EMB_MAX) begin
			return `EMB_MAX;
		end
		return v;
	endfunction

	video_pkg::fmt_state_type state;
	video_pkg::fmt_state_type next_state;
	logic [1:0] code_cnt;
	logic [1:0] next_code_cnt;
	logic code_eav;
	logic next_eav;
	logic chroma_phase;
	logic prev_de_out;
	logic take_c;
	logic next_valid;
	video_pkg::pix_type next_pix;

	// format decode and beat contents
	wire fmt_422 = (active_cfg.fmt == video_pkg::fmt_ycc422_sep);
	wire fmt_mux = (active_cfg.fmt == video_pkg::fmt_ycc422_mux_sep);
	wire emb = (active_cfg.fmt == video_pkg::fmt_ycc422_mux_emb);
	wire muxed = fmt_mux | emb;
	wire adv = ~out_valid | out_ready;
	wire de_edge = emb & (s1_pix.de != prev_de_out);
	wire [7:0] chroma = chroma_phase ? s1_pix.c : s1_pix.b;
	wire [3:0] ctl = {s1_pix.sof, s1_pix.hsync ^ active_cfg.hs_inv, s1_pix.vsync ^ active_cfg.vs_inv, s1_pix.de};
	wire code_v = s1_pix.vsync;
	wire [7:0] xy = {1'b1, 1'b0, code_v, code_eav, code_v ^ code_eav, code_eav, code_v, code_v ^ code_eav};
	wire [7:0] code_byte = (code_cnt == 2'h3) ? xy : `CODE_00;
	assign fmt_take = adv & take_c;

	// beat selection; muxed formats send chroma then luma, codes take four beats
	always_comb begin
		next_state = state;
		next_pix = out_pix;
		next_valid = 1'b0;
		take_c = 1'b0;
		next_code_cnt = code_cnt;
		next_eav = code_eav;
		case (state)
			video_pkg::st_data: begin
				if (s1_valid) begin
					next_valid = 1'b1;
					if (de_edge) begin
						next_pix = {ctl, `CODE_FF, 8'h00, 8'h00};
						next_state = video_pkg::st_code;
						next_code_cnt = 2'h1;
						next_eav = ~s1_pix.de;
					end else if (muxed) begin
						next_pix = {ctl, clamp_emb(chroma, emb), 8'h00, 8'h00};
						next_state = video_pkg::st_luma;
					end else if (fmt_422) begin
						next_pix = {ctl, s1_pix.a, chroma, 8'h00};
						take_c = 1'b1;
					end else begin
						next_pix = {ctl, s1_pix.a, s1_pix.b, s1_pix.c};
						take_c = 1'b1;
					end
				end
			end
			video_pkg::st_luma: begin
				next_valid = 1'b1;
				next_pix = {ctl, clamp_emb(s1_pix.a, emb), 8'h00, 8'h00};
				take_c = 1'b1;
				next_state = video_pkg::st_data;
			end
			video_pkg::st_code: begin
				next_valid = 1'b1;
				next_pix = {ctl, code_byte, 8'h00, 8'h00};
				next_code_cnt = code_cnt + 2'h1;
				if (code_cnt == 2'h3) begin
					next_state = video_pkg::st_data;
				end
			end
			default: begin
				next_state = video_pkg::st_data;
			end
		endcase
	end

	// output register and formatter state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state <= video_pkg::st_data;
			out_pix <= '0;
			out_valid <= 1'b0;
			code_cnt <= 2'h0;
			code_eav <= 1'b0;
		end else if (adv) begin
			state <= next_state;
			out_pix <= next_pix;
			out_valid <= next_valid;
			code_cnt <= next_code_cnt;
			code_eav <= next_eav;
		end
	end

	// chroma alternates Cb, Cr within a line and restarts on Cb in blanking
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			chroma_phase <= 1'b0;
			prev_de_out <= 1'b0;
		end else begin
			if (fmt_take) begin
				chroma_phase <= s1_pix.de ? ~chroma_phase : 1'b0;
			end
			if (adv && state == video_pkg::st_data && s1_valid && de_edge) begin
				prev_de_out <= s1_pix.de;
			end
		end
	end

endmodule

`default_nettype wire

// ### verif/video_path_checker.sv
// checker for the video path top: reset state, output handshake, config loading
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module video_path_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// settings
	input wire logic power_on,
	input wire logic auto_enable,
	input wire logic [1:0] manual_space,
	input wire logic conv_bypass,
	input wire logic decrypt_enable,
	input wire logic hsync_invert,
	input wire video_pkg::format_type out_format,
	// output and status
	input wire video_pkg::pix_type out_pix,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire video_pkg::cfg_type active_cfg,
	input wire logic info_seen
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// each setting lands from the input seen on its loading edge; power follows its input every cycle
	reset_cfg_a: assert property ($fell(rst) |-> active_cfg == '0)
		else $error("config not at reset value");
	power_track_a: assert property (active_cfg.powered == $past(power_on))
		else $error("power state does not follow its input");
	idle_power_a: assert property (!active_cfg.powered && !$past(active_cfg.powered) && !out_valid |=> !out_valid)
		else $error("output while powered down");
	out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_pix))
		else $error("output word dropped during stall");
	manual_space_a: assert property ($changed(active_cfg.space) && !$past(auto_enable)
		|-> active_cfg.space == $past(manual_space))
		else $error("manual space not loaded");
	bypass_load_a: assert property ($changed(active_cfg.conv_on)
		|-> !(active_cfg.conv_on && $past(conv_bypass)))
		else $error("conversion on while bypassed");
	decrypt_load_a: assert property ($changed(active_cfg.decrypt_on)
		|-> active_cfg.decrypt_on == $past(decrypt_enable))
		else $error("decrypt state wrong");
	hs_load_a: assert property ($changed(active_cfg.hs_inv) |-> active_cfg.hs_inv == $past(hsync_invert))
		else $error("sync inversion wrong");
	fmt_load_a: assert property ($changed(active_cfg.fmt) |-> active_cfg.fmt == $past(out_format))
		else $error("output format wrong");
	sep422_a: assert property (out_valid && $past(!out_valid || out_ready)
		&& $past(active_cfg.fmt) == video_pkg::fmt_ycc422_sep |-> out_pix.c == 8'h00)
		else $error("third lane not zero in 4:2:2");
	info_sticky_a: assert property (info_seen |=> info_seen)
		else $error("frame seen flag cleared");

	// main scenarios reached
	cover property (out_valid && out_ready && out_pix.sof);
	cover property ($rose(info_seen));
	cover property ($changed(active_cfg.fmt));
endmodule

bind video_path_color_autoconfig video_path_checker chk (.clock(clock), .rst(rst), .power_on(power_on),
	.auto_enable(auto_enable), .manual_space(manual_space), .conv_bypass(conv_bypass),
	.decrypt_enable(decrypt_enable), .hsync_invert(hsync_invert), .out_format(out_format),
	.out_pix(out_pix), .out_valid(out_valid), .out_ready(out_ready), .active_cfg(active_cfg),
	.info_seen(info_seen));
`default_nettype wire

// ### verif/video_sink.sv
// downstream sink model: takes output beats, counts active ones
// assumes the source holds its word while ready is low
`timescale 1ns/1ps
`default_nettype none

module video_sink (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control from the bench
	input wire logic stall,
	// video input
	input wire logic out_valid,
	input wire video_pkg::pix_type out_pix,
	output logic out_ready
);
	int de_count;
	video_pkg::pix_type last_pix;
	logic toggle;

	// ready every other cycle so the source must hold words
	assign out_ready = !stall && toggle;

	// count accepted active beats, keep the last one
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			toggle <= 1'b0;
			de_count <= 0;
			last_pix <= '0;
		end else begin
			toggle <= !toggle;
			if (out_valid && out_ready && out_pix.de) begin
				de_count <= de_count + 1;
				last_pix <= out_pix;
			end
		end
	end
endmodule
`default_nettype wire

// ### verif/video_path_color_autoconfig_test.sv
// testbench for the video path: frames on the link clock, sink model on the output
// assumes the checker is bound to the top module
`timescale 1ns/1ps
`default_nettype none

module video_path_color_autoconfig_test;
	logic clock, rst, link_clock, link_vsync, link_de, link_ready, info_valid;
	logic [7:0] link_ch0, link_ch1, link_ch2, info_byte1, info_byte2, info_byte5;
	logic power_on, auto_enable, conv_bypass, repl_bypass, decrypt_enable, hsync_invert;
	logic out_valid, out_ready, info_seen, measured_hd, stall;
	logic [1:0] manual_space, manual_colorim;
	logic [3:0] manual_repeat;
	video_pkg::format_type out_format;
	video_pkg::pix_type out_pix;
	video_pkg::cfg_type active_cfg;
	int miscompares, checked, base;

	video_path_color_autoconfig #(.FIFO_DEPTH(8)) dut (.clock(clock), .rst(rst), .link_clock(link_clock),
		.link_hsync(1'b0), .link_vsync(link_vsync), .link_de(link_de), .link_ch0(link_ch0),
		.link_ch1(link_ch1), .link_ch2(link_ch2), .link_ready(link_ready), .info_valid(info_valid),
		.info_byte1(info_byte1), .info_byte2(info_byte2), .info_byte5(info_byte5), .power_on(power_on),
		.auto_enable(auto_enable), .manual_space(manual_space), .manual_colorim(manual_colorim),
		.manual_repeat(manual_repeat), .conv_bypass(conv_bypass), .repl_bypass(repl_bypass),
		.decrypt_enable(decrypt_enable), .hsync_invert(hsync_invert), .vsync_invert(1'b0),
		.out_format(out_format), .out_pix(out_pix), .out_valid(out_valid), .out_ready(out_ready),
		.active_cfg(active_cfg), .info_seen(info_seen), .measured_hd(measured_hd));
	video_sink sink (.clock(clock), .rst(rst), .stall(stall), .out_valid(out_valid), .out_pix(out_pix),
		.out_ready(out_ready));

	// core clock, then a link clock offset in phase
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		link_clock = 1'b0;
		#3;
		forever #40 link_clock = ~link_clock;
	end

	task automatic check(input string what, input logic [27:0] exp, input logic [27:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one link word; the link cannot stall, so nothing waits on ready
	task automatic word(input logic v, input logic d, input logic [23:0] px);
		@(posedge link_clock) #1;
		link_vsync = v;
		link_de = d;
		{link_ch0, link_ch1, link_ch2} = px;
	endtask

	// vsync word opens the frame, blanking around n active words
	task automatic frame(input int n, input logic [23:0] px);
		base = sink.de_count;
		word(1'b1, 1'b0, 24'h000000);
		word(1'b0, 1'b0, 24'h000000);
		for (int i = 0; i < n; i++) word(1'b0, 1'b1, px);
		word(1'b0, 1'b0, 24'h000000);
		word(1'b0, 1'b0, 24'h000000);
	endtask

	task automatic drain(input int n);
		for (int i = 0; i < 1000 && sink.de_count < base + n; i++) @(posedge clock);
		repeat (40) @(posedge clock);
		check("beats", 28'(n), 28'(sink.de_count - base));
	endtask

	task automatic info(input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b5);
		@(posedge link_clock) #1;
		{info_byte1, info_byte2, info_byte5} = {b1, b2, b5};
		info_valid = 1'b1;
		@(posedge link_clock) #1;
		info_valid = 1'b0;
	endtask

	task automatic s_reset();
		check("cfg", 28'h0, 28'(active_cfg));
		check("space", 28'(video_pkg::space_rgb444), 28'(active_cfg.space));
		check("valid", 28'h0, 28'(out_valid));
		@(posedge clock) #1 power_on = 1'b1;
		repeat (2) @(posedge clock);
		check("powered", 28'h1, 28'(active_cfg.powered));
	endtask

	// manual bypass: settings wait for the frame, then data passes untouched
	task automatic s_manual();
		@(posedge clock) #1 out_format = video_pkg::fmt_ycc444_sep;
		decrypt_enable = 1'b1;
		hsync_invert = 1'b1;
		repeat (4) @(posedge clock);
		check("fmt early", 28'(video_pkg::fmt_rgb444_sep), 28'(active_cfg.fmt));
		frame(3, 24'h123456);
		drain(3);
		check("pass", 28'h123456, 28'(sink.last_pix[23:0]));
		check("fmt", 28'(video_pkg::fmt_ycc444_sep), 28'(active_cfg.fmt));
		check("decrypt", 28'h1, 28'(active_cfg.decrypt_on));
		check("lines", 28'h0, 28'(measured_hd));
	endtask

	// black through the matrix in both definitions and back to rgb
	task automatic s_convert();
		logic [1:0] sp [3] = '{2'h0, 2'h0, 2'h2};
		logic [1:0] cm [3] = '{2'h1, 2'h2, 2'h1};
		logic [23:0] din [3] = '{24'h000000, 24'h000000, 24'h108080};
		logic [23:0] dout [3] = '{24'h108080, 24'h108000, 24'h000000};
		for (int i = 0; i < 3; i++) begin
			@(posedge clock) #1 conv_bypass = 1'b0;
			manual_space = sp[i];
			manual_colorim = cm[i];
			out_format = video_pkg::format_type'((i + 1) % 3);
			frame(2, din[i]);
			drain(2);
			check("matrix", 28'(dout[i]), 28'(sink.last_pix[23:0]));
			check("hd", 28'(cm[i] == 2'h2), 28'(active_cfg.hd));
		end
	endtask

	// frame fields drive space, definition, gamut and repetition
	task automatic s_auto();
		logic [7:0] b1 [3] = '{8'h40, 8'h20, 8'h00};
		logic [7:0] b2 [3] = '{8'h80, 8'h40, 8'hc0};
		logic [7:0] b5 [3] = '{8'h01, 8'h03, 8'h00};
		int beats [3] = '{2, 1, 4};
		@(posedge clock) #1 auto_enable = 1'b1;
		conv_bypass = 1'b1;
		repl_bypass = 1'b0;
		for (int i = 0; i < 3; i++) begin
			info(b1[i], b2[i], b5[i]);
			frame(4, 24'h405060);
			drain(beats[i]);
			check("seen", 28'h1, 28'(info_seen));
			check("space", 28'(b1[i][6:5]), 28'(active_cfg.space));
			check("hd", 28'(b2[i][7:6] == 2'h2), 28'(active_cfg.hd));
			check("ext", 28'(b2[i][7:6] == 2'h3), 28'(active_cfg.ext));
			check("rep", 28'(b5[i][3:0]), 28'(active_cfg.repeat_n));
		end
	endtask

	// muxed output gives two beats per pixel; then fill the fifo while stalled
	task automatic s_mux_full();
		@(posedge clock) #1 auto_enable = 1'b0;
		manual_space = 2'h2;
		out_format = video_pkg::fmt_ycc422_mux_sep;
		frame(4, 24'h508080);
		drain(8);
		@(posedge clock) #1 out_format = video_pkg::fmt_ycc422_mux_emb;
		frame(1, 24'h00ff80);
		drain(6);
		check("clamp", 28'h01, 28'(sink.last_pix[23:16]));
		@(posedge clock) #1 stall = 1'b1;
		frame(12, 24'h508080);
		check("full", 28'h0, 28'(link_ready));
		@(posedge clock) #1 stall = 1'b0;
		repeat (300) @(posedge clock);
		check("drained", 28'h1, 28'(link_ready));
		@(posedge clock) #1 power_on = 1'b0;
		frame(2, 24'h508080);
		drain(0);
	endtask

	task automatic results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// reset spans two link edges so the link side leaves reset too
	initial begin
		{rst, stall, info_valid, power_on, auto_enable, conv_bypass, repl_bypass} = 7'h43;
		{decrypt_enable, hsync_invert, manual_space, manual_colorim, manual_repeat} = '0;
		{link_vsync, link_de, link_ch0, link_ch1, link_ch2} = '0;
		{info_byte1, info_byte2, info_byte5} = '0;
		out_format = video_pkg::fmt_rgb444_sep;
		repeat (2) @(posedge link_clock);
		@(posedge clock) #1 rst = 1'b0;
		for (int i = 0; i < 100 && link_ready !== 1'b1; i++) @(posedge clock);
		s_reset();
		s_manual();
		s_convert();
		s_auto();
		s_mux_full();
		results();
	end

	// hang guard
	initial begin
		#500us;
		miscompares++;
		results();
	end
endmodule
`default_nettype wire
